/* File: include/dsce_pkg.sv */
// Purpose: Constants and types for the distance sensor command engine.
// Assumes: 100 MHz ref_clk; ASCII bytes arrive already deframed from the UART.
// Notes: Distances, periods and sensor identifiers travel as packed BCD digits.
// Behaviour
// - Commands and replies are ASCII ending CR LF; act only after LF.
// - After init, send g, own identifier, then question mark.
// - Failed command replies g, identifier, @E and three-digit error code.
// - One plus or minus sign separates mnemonic from parameter.
// - Act only on own identifier; echo identifier in every reply.
// - Stop/clear aborts activity, idles outputs and lamps, replies ready; a measurement in flight still completes and sets the outputs.
// - Single measurement cancels earlier activity, replies eight-digit distance.
// - Bare tracking streams distances, at most 250 per second, until stop.
// - Tracking with parameter streams at millisecond period 0..86400000; zero means fastest.
// - Tracking started on two-wire link ignores stop arriving on that link.
// - Buffered tracking overwrites one-entry buffer; set acknowledged, read returns period.
// - Buffer read returns distance plus how often buffer changed since last read.
// - Change indicator is 0 none, 1 once, 2 more than once.
// - Buffer read fails unless buffered tracking was started.
// - Two limit outputs and one error output; error output follows error state.
// - Trigger enabled turns limit output one into a sampled input.
// - Trigger input fires single measurement or toggles tracking.
// - Normally output lamps follow limit outputs, power on, error off.
// - On sensor error, power and error lamps on, output lamps off, code sent.
// - Factory reset flashes all four lamps for half a second.
// - Firmware wait lights only the second output lamp.
package dsce_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_PERIOD_NS = 1000000;
	localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TRACK_MAX_HZ = 250;
	localparam int GAP_CYCLES = 1000000000 / TRACK_MAX_HZ / CLK_PERIOD_NS;
	localparam int FLASH_MS = 500;
	localparam int FLASH_CYCLES = FLASH_MS * MS_CYCLES;
	localparam int FLASH_BLINK_BIT = 22;
	localparam logic [3:0] INIT_CYCLES = 4'hf;
	localparam logic [31:0] PERIOD_MAX = 32'd86400000;
	localparam logic [3:0] PAR_DIGITS = 4'h8;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_S = 8'h73;
	localparam logic [7:0] CH_G = 8'h67;
	localparam logic [7:0] CH_C = 8'h63;
	localparam logic [7:0] CH_H = 8'h68;
	localparam logic [7:0] CH_F = 8'h66;
	localparam logic [7:0] CH_Q = 8'h71;
	localparam logic [7:0] CH_E = 8'h45;
	localparam logic [7:0] CH_AT = 8'h40;
	localparam logic [7:0] CH_QM = 8'h3f;
	localparam logic [7:0] CH_PLUS = 8'h2b;
	localparam logic [7:0] CH_MINUS = 8'h2d;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [11:0] ERR_SYNTAX = 12'h101;
	localparam logic [11:0] ERR_NO_BUFFER = 12'h102;
	localparam logic [1:0] LINK_P2P = 2'h0;
	localparam logic [1:0] LINK_4W = 2'h1;
	localparam logic [1:0] LINK_2W = 2'h2;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ACTION = 8'h04;
	localparam logic [7:0] ADDR_LIM1 = 8'h08;
	localparam logic [7:0] ADDR_LIM2 = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_DIST = 8'h14;
	localparam logic [7:0] ADDR_ERR = 8'h18;
	localparam int CTRL_TRIG_EN = 8;
	localparam int CTRL_TRIG_MODE = 9;
	localparam int CTRL_FW_WAIT = 10;
	localparam int ACTION_FACTORY = 0;
	localparam logic [7:0] ID_RESET = 8'h00;
	typedef enum logic [2:0] {M_IDLE = 3'b000, M_SINGLE = 3'b001, M_TRACK = 3'b011,
		M_TIMED = 3'b010, M_BUFF = 3'b110} mode_t;
	typedef enum logic [2:0] {P_IDLE = 3'b000, P_ID = 3'b001, P_MN = 3'b011,
		P_PAR = 3'b010, P_CR = 3'b110, P_EXE = 3'b111} pstate_t;
	typedef enum logic [2:0] {K_READY, K_ERR, K_DIST, K_FACK, K_QBUF} kind_t;
	typedef struct packed {
		logic [4:0] len;
		logic [15:0][7:0] b;
	} txbuf_t;
endpackage : dsce_pkg

/* File: src/distance_sensor_command_engine.sv */
// Purpose: ASCII command interpreter of a distance sensor with AHB-Lite control.
// Assumes: Serial bytes, trigger pin and measurement core are synchronous to ref_clk.
// Notes: Replies are assembled whole before sending, so a stream sample that
//   finds the transmitter busy is replaced by the next one rather than queued.
`timescale 1ns/100ps
`default_nettype none
module distance_sensor_command_engine
	import dsce_pkg::*;
	#(
	parameter int MS_CNT = MS_CYCLES,
	parameter int GAP_CNT = GAP_CYCLES,
	parameter int FLASH_CNT = FLASH_CYCLES
	)
	(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Serial receive bytes
	input wire logic rxValid,
	input wire logic [7:0] rxData,
	input wire logic [1:0] rxLink,
	output logic rxReady,
	// Serial transmit bytes
	output logic txValid,
	output logic [7:0] txData,
	input wire logic txReady,
	// Measurement core
	output logic measReq,
	input wire logic measDone,
	input wire logic [31:0] measDist,
	input wire logic measErr,
	input wire logic [11:0] measErrCode,
	// Digital pins
	output logic limitOutputOneOut,
	output logic limitOutputOneOe,
	input wire logic limitOutputOneIn,
	output logic limitOutputTwo,
	output logic errorOutput,
	// Status lamps
	output logic powerLamp,
	output logic errorLamp,
	output logic outputLampOne,
	output logic outputLampTwo
	);

	typedef struct packed {
		pstate_t pst;
		logic [7:0] idAcc;
		logic [1:0] idCnt;
		logic [7:0] mnem;
		logic hasPar;
		logic bad;
		logic [31:0] parBcd;
		logic [31:0] parBin;
		logic [3:0] parCnt;
		logic [1:0] link;
		mode_t mode;
		logic locked;
		logic [31:0] period;
		logic [31:0] periodBcd;
		logic [31:0] msDiv;
		logic [31:0] msCnt;
		logic [31:0] gap;
		logic due;
		logic measReq;
		logic measBusy;
		logic [31:0] lastDist;
		logic lastValid;
		logic [31:0] bufDist;
		logic [1:0] bufCnt;
		logic errActive;
		logic [11:0] errCode;
		logic strPend;
		logic strErr;
		logic [7:0] strMn;
		logic [31:0] strDist;
		txbuf_t tx;
		logic [4:0] txIdx;
		logic [3:0] initCnt;
		logic startDone;
		logic [31:0] flashCnt;
		logic trigPrev;
		logic [7:0] sensorId;
		logic trigEn;
		logic trigMode;
		logic fwWait;
		logic [31:0] lim1;
		logic [31:0] lim2;
		logic wrPend;
		logic [7:0] addr;
		logic [31:0] rdata;
	} st_t;

	st_t st_reg;
	st_t st_next;
	logic execNow;
	logic lockedHere;
	logic txIdle;
	logic free;
	logic addrPhase;
	logic trigRise;
	logic want;

	function automatic logic isDigit(input logic [7:0] c);
		return c >= CH_ZERO && c <= 8'h39;
	endfunction : isDigit

	function automatic logic [7:0] asc(input logic [3:0] d);
		return CH_ZERO | {4'h0, d};
	endfunction : asc

	function automatic txbuf_t compose(input kind_t kind, input logic [7:0] id,
		input logic [7:0] mn, input logic [31:0] dig, input logic [11:0] code,
		input logic [1:0] cnt);
		txbuf_t t;
		t = '0;
		t.b[t.len[3:0]] = CH_G;
		t.len = t.len + 5'd1;
		if (id[7:4] != 4'h0)
		begin
			t.b[t.len[3:0]] = asc(id[7:4]);
			t.len = t.len + 5'd1;
		end
		t.b[t.len[3:0]] = asc(id[3:0]);
		t.len = t.len + 5'd1;
		unique case (kind)
			K_READY:
			begin
				t.b[t.len[3:0]] = CH_QM;
				t.len = t.len + 5'd1;
			end
			K_ERR:
			begin
				t.b[t.len[3:0]] = CH_AT;
				t.b[t.len[3:0] + 4'd1] = CH_E;
				for (int i = 2; i >= 0; i--)
				begin
					t.b[t.len[3:0] + 4'(4 - i)] = asc(code[i*4 +: 4]);
				end
				t.len = t.len + 5'd5;
			end
			K_FACK:
			begin
				t.b[t.len[3:0]] = CH_F;
				t.b[t.len[3:0] + 4'd1] = CH_QM;
				t.len = t.len + 5'd2;
			end
			K_DIST, K_QBUF:
			begin
				t.b[t.len[3:0]] = mn;
				t.b[t.len[3:0] + 4'd1] = CH_PLUS;
				for (int i = 7; i >= 0; i--)
				begin
					t.b[t.len[3:0] + 4'(9 - i)] = asc(dig[i*4 +: 4]);
				end
				t.len = t.len + 5'd10;
				if (kind == K_QBUF)
				begin
					t.b[t.len[3:0]] = CH_PLUS;
					t.b[t.len[3:0] + 4'd1] = asc({2'b00, cnt});
					t.len = t.len + 5'd2;
				end
			end
		endcase
		t.b[t.len[3:0]] = CH_CR;
		t.b[t.len[3:0] + 4'd1] = CH_LF;
		t.len = t.len + 5'd2;
		return t;
	endfunction : compose

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		st_next = st_reg;
		st_next.measReq = 1'b0;
		execNow = 1'b0;
		txIdle = st_reg.txIdx == st_reg.tx.len;
		free = txIdle && st_reg.startDone;
		lockedHere = st_reg.locked && st_reg.link == LINK_2W;
		addrPhase = hsel && htrans[1] && hready;
		trigRise = st_reg.trigEn && limitOutputOneIn && !st_reg.trigPrev;
		st_next.trigPrev = limitOutputOneIn;
		// Zero wait state slave: reads are captured in the address phase.
		st_next.wrPend = addrPhase && hwrite;
		if (addrPhase)
		begin
			st_next.addr = haddr[7:0];
			unique case (haddr[7:0])
				ADDR_CTRL: st_next.rdata = {21'h0, st_reg.fwWait, st_reg.trigMode,
					st_reg.trigEn, st_reg.sensorId};
				ADDR_LIM1: st_next.rdata = st_reg.lim1;
				ADDR_LIM2: st_next.rdata = st_reg.lim2;
				ADDR_STATUS: st_next.rdata = {25'h0, st_reg.locked, st_reg.bufCnt,
					st_reg.errActive, st_reg.mode};
				ADDR_DIST: st_next.rdata = st_reg.lastDist;
				ADDR_ERR: st_next.rdata = {20'h0, st_reg.errCode};
				default: st_next.rdata = 32'h0;
			endcase
		end
		if (st_reg.wrPend)
		begin
			unique case (st_reg.addr)
				ADDR_CTRL:
				begin
					st_next.sensorId = hwdata[7:0];
					st_next.trigEn = hwdata[CTRL_TRIG_EN];
					st_next.trigMode = hwdata[CTRL_TRIG_MODE];
					st_next.fwWait = hwdata[CTRL_FW_WAIT];
				end
				ADDR_ACTION:
				begin
					if (hwdata[ACTION_FACTORY])
					begin
						st_next.flashCnt = 32'(FLASH_CNT);
						st_next.sensorId = ID_RESET;
						st_next.trigEn = 1'b0;
						st_next.trigMode = 1'b0;
					end
				end
				ADDR_LIM1: st_next.lim1 = hwdata;
				ADDR_LIM2: st_next.lim2 = hwdata;
				default: st_next.addr = st_reg.addr;
			endcase
		end
		if (txValid && txReady)
		begin
			st_next.txIdx = st_reg.txIdx + 5'd1;
		end
		if (st_reg.gap != 32'h0)
		begin
			st_next.gap = st_reg.gap - 32'd1;
		end
		if (st_reg.flashCnt != 32'h0)
		begin
			st_next.flashCnt = st_reg.flashCnt - 32'd1;
		end
		if ((st_reg.mode == M_TIMED || st_reg.mode == M_BUFF) && st_reg.period != 32'h0)
		begin
			if (st_reg.msDiv >= 32'(MS_CNT - 1))
			begin
				st_next.msDiv = 32'h0;
				if (st_reg.msCnt >= st_reg.period - 32'd1)
				begin
					st_next.msCnt = 32'h0;
					st_next.due = 1'b1;
				end
				else
				begin
					st_next.msCnt = st_reg.msCnt + 32'd1;
				end
			end
			else
			begin
				st_next.msDiv = st_reg.msDiv + 32'd1;
			end
		end
		if (!st_reg.startDone)
		begin
			if (st_reg.initCnt == INIT_CYCLES)
			begin
				st_next.tx = compose(K_READY, st_reg.sensorId, CH_G, 32'h0, 12'h0, 2'h0);
				st_next.txIdx = 5'd0;
				st_next.startDone = 1'b1;
			end
			else
			begin
				st_next.initCnt = st_reg.initCnt + 4'd1;
			end
		end
		////////////////////////////////////////////////////////////////////////
		if (rxValid && rxReady)
		begin
			if (rxData == CH_LF)
			begin
				st_next.pst = st_reg.pst == P_CR ? P_EXE : P_IDLE;
			end
			else if (rxData == CH_CR)
			begin
				st_next.pst = st_reg.pst == P_IDLE ? P_IDLE : P_CR;
			end
			else
			begin
				unique case (st_reg.pst)
					P_IDLE:
					begin
						if (rxData == CH_S)
						begin
							st_next.pst = P_ID;
							st_next.idAcc = 8'h0;
							st_next.idCnt = 2'd0;
							st_next.hasPar = 1'b0;
							st_next.bad = 1'b0;
							st_next.parBcd = 32'h0;
							st_next.parBin = 32'h0;
							st_next.parCnt = 4'h0;
							st_next.link = rxLink;
						end
					end
					P_ID:
					begin
						if (isDigit(rxData))
						begin
							st_next.idAcc = {st_reg.idAcc[3:0], rxData[3:0]};
							st_next.idCnt = st_reg.idCnt + 2'd1;
							st_next.bad = st_reg.bad || st_reg.idCnt == 2'd2;
						end
						else
						begin
							st_next.mnem = rxData;
							st_next.pst = P_MN;
						end
					end
					P_MN:
					begin
						if (rxData == CH_PLUS || rxData == CH_MINUS)
						begin
							st_next.hasPar = 1'b1;
							st_next.pst = P_PAR;
						end
						else
						begin
							st_next.bad = 1'b1;
						end
					end
					P_PAR:
					begin
						if (isDigit(rxData) && st_reg.parCnt < PAR_DIGITS)
						begin
							st_next.parBcd = {st_reg.parBcd[27:0], rxData[3:0]};
							st_next.parBin = 32'(st_reg.parBin * 32'd10) + {28'h0, rxData[3:0]};
							st_next.parCnt = st_reg.parCnt + 4'd1;
						end
						else
						begin
							st_next.bad = 1'b1;
						end
					end
					P_CR: st_next.bad = 1'b1;
					P_EXE: st_next.bad = st_reg.bad;
				endcase
			end
		end
		////////////////////////////////////////////////////////////////////////
		// Commands wait in P_EXE until the transmitter is free; rxReady holds the host off.
		if (st_reg.pst == P_EXE && free)
		begin
			st_next.pst = P_IDLE;
			if (st_reg.idCnt != 2'd0 && st_reg.idAcc == st_reg.sensorId && !lockedHere)
			begin
				execNow = 1'b1;
				st_next.errCode = ERR_SYNTAX;
				st_next.tx = compose(K_ERR, st_reg.sensorId, CH_G, 32'h0, ERR_SYNTAX, 2'h0);
				st_next.txIdx = 5'd0;
				if (st_reg.hasPar && (st_reg.parCnt != PAR_DIGITS || st_reg.parBin > PERIOD_MAX))
				begin
					st_next.bad = 1'b1;
				end
				else if (!st_reg.bad)
				begin
					unique case (st_reg.mnem)
						CH_C:
						begin
							st_next.mode = M_IDLE;
							st_next.locked = 1'b0;
							st_next.errActive = 1'b0;
							st_next.lastValid = 1'b0;
							st_next.due = 1'b0;
							st_next.strPend = 1'b0;
							st_next.tx = compose(K_READY, st_reg.sensorId, CH_G, 32'h0, 12'h0, 2'h0);
						end
						CH_G:
						begin
							if (!st_reg.hasPar)
							begin
								st_next.mode = M_SINGLE;
								st_next.due = 1'b1;
								st_next.locked = 1'b0;
								st_next.tx = st_reg.tx;
								st_next.txIdx = st_reg.txIdx;
							end
						end
						CH_H:
						begin
							st_next.mode = st_reg.hasPar && st_reg.parBin != 32'h0 ? M_TIMED : M_TRACK;
							st_next.period = st_reg.parBin;
							st_next.msDiv = 32'h0;
							st_next.msCnt = 32'h0;
							st_next.due = 1'b1;
							st_next.locked = st_reg.link == LINK_2W;
							st_next.tx = st_reg.tx;
							st_next.txIdx = st_reg.txIdx;
						end
						CH_F:
						begin
							if (st_reg.hasPar)
							begin
								st_next.mode = M_BUFF;
								st_next.period = st_reg.parBin;
								st_next.periodBcd = st_reg.parBcd;
								st_next.msDiv = 32'h0;
								st_next.msCnt = 32'h0;
								st_next.due = 1'b1;
								st_next.bufCnt = 2'd0;
								st_next.locked = 1'b0;
								st_next.tx = compose(K_FACK, st_reg.sensorId, CH_F, 32'h0, 12'h0, 2'h0);
							end
							else
							begin
								st_next.tx = compose(K_DIST, st_reg.sensorId, CH_F, st_reg.periodBcd,
									12'h0, 2'h0);
							end
						end
						CH_Q:
						begin
							if (st_reg.mode != M_BUFF)
							begin
								st_next.tx = compose(K_ERR, st_reg.sensorId, CH_G, 32'h0,
									ERR_NO_BUFFER, 2'h0);
							end
							else
							begin
								st_next.tx = compose(K_QBUF, st_reg.sensorId, CH_H, st_reg.bufDist,
									12'h0, st_reg.bufCnt);
								st_next.bufCnt = 2'd0;
							end
						end
						default: st_next.bad = 1'b1;
					endcase
				end
			end
		end
		free = free && !execNow;
		if (trigRise)
		begin
			st_next.locked = 1'b0;
			if (!st_reg.trigMode)
			begin
				st_next.mode = M_SINGLE;
				st_next.due = 1'b1;
			end
			else
			begin
				st_next.mode = st_reg.mode == M_TRACK ? M_IDLE : M_TRACK;
			end
		end
		// Completion is applied after stop so a same-cycle error still sets the flag.
		if (measDone && st_reg.measBusy)
		begin
			st_next.measBusy = 1'b0;
			st_next.lastDist = measDist;
			st_next.lastValid = !measErr;
			st_next.strDist = measDist;
			if (measErr)
			begin
				st_next.errActive = 1'b1;
				st_next.errCode = measErrCode;
				st_next.strErr = 1'b1;
				st_next.strPend = 1'b1;
			end
			else
			begin
				st_next.strErr = 1'b0;
				unique case (st_next.mode)
					M_SINGLE:
					begin
						st_next.strPend = 1'b1;
						st_next.strMn = CH_G;
						st_next.mode = M_IDLE;
					end
					M_TRACK, M_TIMED:
					begin
						st_next.strPend = 1'b1;
						st_next.strMn = CH_H;
					end
					M_BUFF:
					begin
						st_next.bufDist = measDist;
						// Counts on top of a same-cycle read so that update is not lost.
						st_next.bufCnt = st_next.bufCnt == 2'd2 ? 2'd2 : st_next.bufCnt + 2'd1;
					end
					M_IDLE: st_next.strPend = 1'b0;
				endcase
			end
		end
		if (free && st_reg.strPend)
		begin
			st_next.strPend = 1'b0;
			st_next.tx = compose(st_reg.strErr ? K_ERR : K_DIST, st_reg.sensorId, st_reg.strMn,
				st_reg.strDist, st_reg.errCode, 2'h0);
			st_next.txIdx = 5'd0;
		end
		want = (st_reg.mode == M_SINGLE && st_reg.due)
			|| ((st_reg.mode == M_TRACK || st_reg.period == 32'h0) && st_reg.mode != M_IDLE
			&& st_reg.mode != M_SINGLE && st_reg.gap == 32'h0)
			|| ((st_reg.mode == M_TIMED || st_reg.mode == M_BUFF) && st_reg.due);
		if (!st_reg.measBusy && want)
		begin
			st_next.measReq = 1'b1;
			st_next.measBusy = 1'b1;
			st_next.due = 1'b0;
			st_next.gap = 32'(GAP_CNT);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		hrdata = st_reg.rdata;
		hreadyout = 1'b1;
		hresp = 1'b0;
		rxReady = st_reg.pst != P_EXE;
		txValid = !txIdle;
		txData = st_reg.tx.b[st_reg.txIdx[3:0]];
		measReq = st_reg.measReq;
		errorOutput = st_reg.errActive;
		limitOutputOneOe = !st_reg.trigEn;
		limitOutputOneOut = !st_reg.trigEn && !st_reg.errActive && st_reg.lastValid
			&& st_reg.lastDist > st_reg.lim1;
		limitOutputTwo = !st_reg.errActive && st_reg.lastValid && st_reg.lastDist > st_reg.lim2;
		if (st_reg.flashCnt != 32'h0)
		begin
			powerLamp = st_reg.flashCnt[FLASH_BLINK_BIT];
			errorLamp = st_reg.flashCnt[FLASH_BLINK_BIT];
			outputLampOne = st_reg.flashCnt[FLASH_BLINK_BIT];
			outputLampTwo = st_reg.flashCnt[FLASH_BLINK_BIT];
		end
		else if (st_reg.fwWait)
		begin
			{powerLamp, errorLamp, outputLampOne, outputLampTwo} = 4'b0001;
		end
		else
		begin
			powerLamp = 1'b1;
			errorLamp = st_reg.errActive;
			outputLampOne = limitOutputOneOut;
			outputLampTwo = limitOutputTwo;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	chk_reply_crlf: assert property (txValid |-> st_reg.tx.b[4'(st_reg.tx.len - 5'd1)] == CH_LF
		&& st_reg.tx.b[4'(st_reg.tx.len - 5'd2)] == CH_CR) else $error("reply not CR LF");
	chk_startup_ready: assert property ($rose(st_reg.startDone) |-> txValid
		&& txData == CH_G) else $error("no ready string");
	chk_error_form: assert property (execNow && st_reg.bad && st_reg.sensorId[7:4] == 4'h0
		|=> st_reg.tx.b[2] == CH_AT && st_reg.tx.b[3] == CH_E) else $error("bad error form");
	chk_stop_idle: assert property (execNow && !st_reg.bad && st_reg.mnem == CH_C && !measDone
		&& !trigRise |=> st_reg.mode == M_IDLE && !limitOutputTwo && !errorOutput)
		else $error("stop left activity");
	chk_single_req: assert property (execNow && !st_reg.bad && st_reg.mnem == CH_G
		&& !st_reg.hasPar && !st_reg.measBusy |-> ##[1:2] measReq) else $error("no measure");
	chk_two_wire_lock: assert property (st_reg.pst == P_EXE && free && lockedHere
		&& !trigRise |=> st_reg.locked) else $error("two-wire stop accepted");
	chk_no_buffer: assert property (execNow && !st_reg.bad && st_reg.mnem == CH_Q
		&& st_reg.mode != M_BUFF && st_reg.sensorId[7:4] == 4'h0 |=> st_reg.tx.b[2] == CH_AT)
		else $error("read without buffer");
	chk_buffer_count: assert property (st_reg.bufCnt != 2'd3) else $error("bad count");
	chk_error_output: assert property (measDone && st_reg.measBusy && measErr
		|=> errorOutput) else $error("error output missed");
	chk_trigger_pin: assert property (st_reg.trigEn |-> !limitOutputOneOe
		&& !limitOutputOneOut) else $error("trigger pin driven");
	chk_error_lamps: assert property (st_reg.errActive && st_reg.flashCnt == 32'h0
		&& !st_reg.fwWait |-> powerLamp && errorLamp && !outputLampOne && !outputLampTwo)
		else $error("error lamps wrong");
	chk_firmware_lamps: assert property (st_reg.fwWait && st_reg.flashCnt == 32'h0
		|-> !powerLamp && !errorLamp && !outputLampOne && outputLampTwo)
		else $error("firmware lamps wrong");

	cov_single: cover property (st_reg.mode == M_SINGLE ##[1:100] st_reg.strPend);
	cov_track: cover property (st_reg.mode == M_TRACK && measReq);
	cov_buffer_read: cover property (execNow && st_reg.mnem == CH_Q && st_reg.bufCnt == 2'd2);
	cov_flash: cover property (st_reg.flashCnt != 32'h0 && powerLamp);
endmodule : distance_sensor_command_engine
`default_nettype wire

/* File: test/sensor_host_model.sv */
// Purpose: Host side model: takes reply bytes slowly and answers measurements.
// Assumes: One outstanding measurement; distance is a fixed BCD value.
// Notes: Reply bytes gather in got for the bench to compare.
`timescale 1ns/100ps
`default_nettype none
module sensor_host_model
	(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Engine side
	input wire logic measReq,
	input wire logic txValid,
	input wire logic [7:0] txData,
	output logic measDone,
	output logic [31:0] measDist,
	output logic measErr,
	output logic [11:0] measErrCode,
	output logic txReady
	);
	string got;
	logic [1:0] cnt;
	logic injectErr = 1'b0;
	assign measDist = 32'h00001234;
	assign measErr = injectErr;
	assign measErrCode = 12'h321;
	// Ready toggles so the transmitter sees a stalling host.
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txReady <= 1'b0;
			measDone <= 1'b0;
			cnt <= 2'h0;
		end
		else
		begin
			txReady <= ~txReady;
			if (txValid && txReady)
				got = $sformatf("%s%c", got, txData);
			measDone <= (cnt == 2'h1);
			cnt <= measReq ? 2'h3 : (cnt != 2'h0 ? cnt - 2'h1 : 2'h0);
		end
	end
endmodule : sensor_host_model
`default_nettype wire

/* File: test/distance_sensor_command_engine_bench.sv */
// Purpose: Self-checking bench of the command engine.
// Assumes: Short timing parameters; one AHB master, host model on the far side.
// Notes: Replies are compared as whole strings.
`timescale 1ns/100ps
`default_nettype none
module distance_sensor_command_engine_bench;
	import dsce_pkg::*;
	logic ref_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, rxValid = 0, trig = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, measDist;
	logic [1:0] htrans = 0, rxLink = 0;
	logic [7:0] rxData = 0, txData;
	logic [11:0] measErrCode;
	logic hreadyout, hresp, rxReady, txValid, txReady, measReq, measDone, measErr, l1o, l1e;
	logic l2, eo, pl, el, ol1, ol2;
	int miscompares = 0, nCompared = 0;
	distance_sensor_command_engine #(.MS_CNT(10), .GAP_CNT(20), .FLASH_CNT(64))
		distance_sensor_command_engine_inst (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.rxValid(rxValid), .rxData(rxData), .rxLink(rxLink), .rxReady(rxReady),
		.txValid(txValid), .txData(txData), .txReady(txReady), .measReq(measReq),
		.measDone(measDone), .measDist(measDist), .measErr(measErr),
		.measErrCode(measErrCode), .limitOutputOneOut(l1o), .limitOutputOneOe(l1e),
		.limitOutputOneIn(trig), .limitOutputTwo(l2), .errorOutput(eo), .powerLamp(pl),
		.errorLamp(el), .outputLampOne(ol1), .outputLampTwo(ol2));
	sensor_host_model sensor_host_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.measReq(measReq), .txValid(txValid), .txData(txData), .measDone(measDone),
		.measDist(measDist), .measErr(measErr), .measErrCode(measErrCode),
		.txReady(txReady));
	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task complete_run;
		if (miscompares == 0 && nCompared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	task check(input string seen, input string exp);
		nCompared++;
		if (seen != exp)
		begin
			miscompares++;
			$display("Error at %0t: saw %s, expected %s", $time, seen, exp);
		end
	endtask : check
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 100);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 100);
		rd = hrdata;
		hsel <= 1'b0;
		if (n >= 100)
		begin
			miscompares++;
			complete_run();
		end
	endtask : ahb
	// Sends one frame with its terminator, holding each byte until taken.
	task send(input string s);
		int i;
		int n;
		s = {s, "\r\n"};
		for (i = 0; i < s.len(); i++)
		begin
			rxValid <= 1'b1;
			rxData <= s[i];
			n = 0;
			do @(posedge ref_clk); while (rxReady !== 1'b1 && ++n < 500);
			if (n >= 500)
			begin
				miscompares++;
				complete_run();
			end
		end
		rxValid <= 1'b0;
	endtask : send
	task reply(input string e);
		int n;
		n = 0;
		while (sensor_host_model_inst.got.len() < e.len() + 2 && ++n < 3000)
			@(posedge ref_clk);
		if (n >= 3000)
		begin
			miscompares++;
			complete_run();
		end
		check(sensor_host_model_inst.got, {e, "\r\n"});
		sensor_host_model_inst.got = "";
	endtask : reply
	////////////////////////////////////////////////////////////////////////////////
	task startup_and_single;
		reply("g0?");
		send("s0g");
		reply("g0g+00001234");
	endtask : startup_and_single
	task errors_and_foreign_id;
		send("s7g");
		send("s0z");
		reply("g0@E101");
		send("s0q");
		reply("g0@E102");
	endtask : errors_and_foreign_id
	task new_id_and_stop;
		ahb(1'b1, ADDR_CTRL, 32'h00000005);
		send("s05c");
		reply("g5?");
		ahb(1'b0, ADDR_STATUS, 32'h0);
		check($sformatf("%h", rd[2:0]), "0");
		check($sformatf("%b%b%b%b", pl, el, ol1, ol2), "1000");
		ahb(1'b0, 8'h40, 32'h0);
		check($sformatf("%h", rd), "00000000");
	endtask : new_id_and_stop
	// Stream replies keep coming until the stop, so only the tail of got is judged.
	task tracking_and_stop;
		int n;
		string g;
		send("s5h");
		reply("g5h+00001234");
		send("s5c");
		n = 0;
		do
		begin
			@(posedge ref_clk);
			g = sensor_host_model_inst.got;
			if (g.len() >= 5)
				g = g.substr(g.len() - 5, g.len() - 1);
		end
		while (g != "g5?\r\n" && ++n < 3000);
		check(g, "g5?\r\n");
		if (n >= 3000)
			complete_run();
		sensor_host_model_inst.got = "";
		repeat (100) @(posedge ref_clk);
		check(sensor_host_model_inst.got, "");
	endtask : tracking_and_stop
	task trigger_single;
		ahb(1'b1, ADDR_CTRL, 32'h00000105);
		@(negedge ref_clk);
		check($sformatf("%b%b", l1e, l1o), "00");
		@(posedge ref_clk);
		trig <= 1'b1;
		repeat (3) @(posedge ref_clk);
		trig <= 1'b0;
		reply("g5g+00001234");
		ahb(1'b1, ADDR_CTRL, 32'h00000005);
	endtask : trigger_single
	task sensor_error;
		sensor_host_model_inst.injectErr <= 1'b1;
		send("s5g");
		reply("g5@E321");
		check($sformatf("%b%b%b%b%b", eo, pl, el, ol1, ol2), "11100");
		sensor_host_model_inst.injectErr <= 1'b0;
		send("s5c");
		reply("g5?");
		check($sformatf("%b", eo), "0");
	endtask : sensor_error
	initial
	begin
		sensor_host_model_inst.got = "";
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		startup_and_single();
		errors_and_foreign_id();
		new_id_and_stop();
		tracking_and_stop();
		trigger_single();
		sensor_error();
		complete_run();
	end
endmodule : distance_sensor_command_engine_bench
`default_nettype wire
